// >>> src/rmls_pkg.sv
// Purpose: shared constants and carriers of the regulator mask / load select block
// Assumes: 8-bit register port driven by the serial interface engine
// Notes: channel index 0 sw0, 1 sw1, 2 lin0, 3 lin1
`default_nettype none
package rmls_pkg;
  localparam int RMLS_NCH = 4;
  // register offsets
  localparam logic [7:0] RMLS_OFS_TOP_MASK_FIRST = 8'h20;
  localparam logic [7:0] RMLS_OFS_TOP_MASK_SECOND = 8'h21;
  localparam logic [7:0] RMLS_OFS_SW_MASK = 8'h22;
  localparam logic [7:0] RMLS_OFS_LIN_MASK = 8'h23;
  localparam logic [7:0] RMLS_OFS_LOAD_SEL = 8'h24;
  localparam logic [7:0] RMLS_OFS_LOAD_HIGH = 8'h25;
  localparam logic [7:0] RMLS_OFS_LOAD_LOW = 8'h26;
  // reset values
  localparam logic [7:0] RMLS_RST_TOP_MASK_FIRST = 8'h91;
  localparam logic [7:0] RMLS_RST_TOP_MASK_SECOND = 8'h01;
  localparam logic [7:0] RMLS_RST_REG_MASK = 8'hDD;
  localparam logic [7:0] RMLS_RST_LOAD_SEL = 8'h00;
  // writable bits of the per-regulator mask registers
  localparam logic [7:0] RMLS_REG_MASK_WR = 8'hDD;
  // field positions inside a regulator mask byte, per unit slot, then inside the other registers
  localparam int RMLS_SLOT_STRIDE = 4;
  localparam int RMLS_POS_FALL = 3;
  localparam int RMLS_POS_RISE = 2;
  localparam int RMLS_POS_OC = 0;
  localparam int RMLS_POS_RESET_REG_BLOCK = 0;
  localparam int RMLS_POS_MEAS_READY_BLOCK = 0;
  localparam int RMLS_POS_BUCK_SELECT = 0;
  localparam int RMLS_POS_LOAD_MSB = 0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rmls_req_t;

  // pg: 1 means output invalid; oc: 1 means current limit active
  typedef struct packed {
    logic [RMLS_NCH-1:0] pg;
    logic [RMLS_NCH-1:0] oc;
  } rmls_raw_t;

  typedef struct packed {
    logic reset_reg;
    logic meas_ready;
    logic [RMLS_NCH-1:0] pg;
    logic [RMLS_NCH-1:0] oc;
  } rmls_flags_t;

  typedef enum logic [1:0] {
    RMLS_MEAS_IDLE = 2'b01,
    RMLS_MEAS_BUSY = 2'b10
  } rmls_meas_st_t;
endpackage : rmls_pkg
`default_nettype wire

// >>> src/rmls_top.sv
// Purpose: interrupt masks of the regulators and load-current measurement select
// Assumes: register port comes from the serial engine, one access per cycle
// Notes: flag registers live here but their readback/clear path is outside
//
// Overview of operation
// - reset-register interrupt mask at 0x21 bit 0; 1 blocks; defaults to 1.
// - that mask bit reloads from nonvolatile memory on every reset.
// - buck mask bits 7/3 block buck1/buck0 power-good invalid interrupts.
// - buck mask bits 6/2 block buck1/buck0 power-good valid interrupts.
// - buck mask bits 4/0 block buck1/buck0 current-limit interrupts.
// - buck masks never alter the buck raw status bits.
// - linear mask at 0x23 bits 7/3 block regulator power-good invalid interrupts.
// - linear mask bits 6/2 block regulator power-good valid interrupts.
// - linear mask bits 4/0 block regulator current-limit interrupts.
// - linear masks never alter the linear raw status bits.
// - select bit 0 picks buck 0 or buck 1 for measurement; default 0.
// - every write to the select register starts a new measurement.
// - result is 9 bits at 20 mA per step, high bit and low byte.
// - finished measurement raises ready interrupt unless its mask bit blocks it.
`default_nettype none
module rmls_top
  import rmls_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // register port
  input wire rmls_req_t req_in,
  output logic [7:0] rd_data_out,
  // regulator condition inputs and events
  input wire rmls_raw_t raw_in,
  input wire logic reset_reg_event_in,
  input wire logic otp_reset_reg_block_in,
  // flag clears from the flag register logic
  input wire rmls_flags_t flag_clr_in,
  // measurement engine
  input wire logic meas_done_in,
  input wire logic [8:0] meas_value_in,
  output logic meas_start_out,
  output logic meas_sel_out,
  output logic meas_busy_out,
  // flags and status
  output rmls_flags_t flags_out,
  output rmls_raw_t raw_seen_out
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // one mask bit of the slot that a channel occupies in its register
  function automatic logic slot_bit(input logic [7:0] m, input int ch, input int pos);
    slot_bit = m[(ch % 2) * RMLS_SLOT_STRIDE + pos];
  endfunction

  logic [7:0] top_mask_first_ff;
  logic [7:0] top_mask_second_ff;
  logic [7:0] sw_mask_ff;
  logic [7:0] lin_mask_ff;
  logic [7:0] load_sel_ff;
  logic load_msb_ff;
  logic [7:0] load_low_ff;
  logic otp_load_ff;
  rmls_raw_t raw_prev_ff;
  rmls_flags_t flags_ff;
  rmls_raw_t raw_seen_ff;
  rmls_meas_st_t meas_st_ff;
  rmls_meas_st_t nxt_meas_st;
  logic meas_start_ff;
  logic [7:0] rd_data_ff;
  logic [7:0] nxt_rd_data;
  logic sel_wr;
  logic [RMLS_NCH-1:0] fall_evt;
  logic [RMLS_NCH-1:0] rise_evt;
  logic [RMLS_NCH-1:0] oc_evt;
  logic [RMLS_NCH-1:0] pg_set;
  logic [RMLS_NCH-1:0] oc_set;
  logic meas_ready_set;
  logic reset_reg_set;

  assign sel_wr = req_in.wr && hit(req_in.addr, RMLS_OFS_LOAD_SEL);

  // mask byte 0x21; async reset only loads a constant, otp level taken after release
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      top_mask_second_ff <= RMLS_RST_TOP_MASK_SECOND;
      otp_load_ff <= 1'b1;
    end else begin
      otp_load_ff <= 1'b0;
      if (otp_load_ff) begin
        top_mask_second_ff[RMLS_POS_RESET_REG_BLOCK] <= otp_reset_reg_block_in;
      end else if (req_in.wr && hit(req_in.addr, RMLS_OFS_TOP_MASK_SECOND)) begin
        top_mask_second_ff <= req_in.wdata;
      end
    end
  end

  // remaining mask and select registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      top_mask_first_ff <= RMLS_RST_TOP_MASK_FIRST;
      sw_mask_ff <= RMLS_RST_REG_MASK;
      lin_mask_ff <= RMLS_RST_REG_MASK;
      load_sel_ff <= RMLS_RST_LOAD_SEL;
    end else if (req_in.wr) begin
      if (hit(req_in.addr, RMLS_OFS_TOP_MASK_FIRST)) begin
        top_mask_first_ff <= req_in.wdata;
      end
      if (hit(req_in.addr, RMLS_OFS_SW_MASK)) begin
        sw_mask_ff <= req_in.wdata & RMLS_REG_MASK_WR;
      end
      if (hit(req_in.addr, RMLS_OFS_LIN_MASK)) begin
        lin_mask_ff <= req_in.wdata & RMLS_REG_MASK_WR;
      end
      if (sel_wr) begin
        load_sel_ff <= req_in.wdata;
      end
    end
  end

  // edge detection on the raw conditions; masks never touch the raw path
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      raw_prev_ff <= '0;
      raw_seen_ff <= '0;
    end else begin
      raw_prev_ff <= raw_in;
      raw_seen_ff <= raw_in;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < RMLS_NCH; ch++) begin : g_ch
      logic [7:0] m;
      assign m = (ch < 2) ? sw_mask_ff : lin_mask_ff;
      assign fall_evt[ch] = raw_in.pg[ch] && !raw_prev_ff.pg[ch];
      assign rise_evt[ch] = !raw_in.pg[ch] && raw_prev_ff.pg[ch];
      assign oc_evt[ch] = raw_in.oc[ch] && !raw_prev_ff.oc[ch];
      // each direction gated on its own bit
      assign pg_set[ch] = (fall_evt[ch] && !slot_bit(m, ch, RMLS_POS_FALL))
        || (rise_evt[ch] && !slot_bit(m, ch, RMLS_POS_RISE));
      assign oc_set[ch] = oc_evt[ch] && !slot_bit(m, ch, RMLS_POS_OC);
    end
  endgenerate

  assign reset_reg_set = reset_reg_event_in
    && !top_mask_second_ff[RMLS_POS_RESET_REG_BLOCK];
  assign meas_ready_set = meas_done_in && (meas_st_ff == RMLS_MEAS_BUSY)
    && !top_mask_first_ff[RMLS_POS_MEAS_READY_BLOCK];

  // sticky flags; a set in the clearing cycle wins so no event is lost
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_ff <= '0;
    end else begin
      flags_ff.pg <= (flags_ff.pg & ~flag_clr_in.pg) | pg_set;
      flags_ff.oc <= (flags_ff.oc & ~flag_clr_in.oc) | oc_set;
      flags_ff.reset_reg <= (flags_ff.reset_reg && !flag_clr_in.reset_reg) || reset_reg_set;
      flags_ff.meas_ready <= (flags_ff.meas_ready && !flag_clr_in.meas_ready)
        || meas_ready_set;
    end
  end

  // measurement sequencing; a write while busy restarts the engine
  always_comb begin
    nxt_meas_st = meas_st_ff;
    case (meas_st_ff)
      RMLS_MEAS_IDLE: begin
        if (sel_wr) begin
          nxt_meas_st = RMLS_MEAS_BUSY;
        end
      end
      RMLS_MEAS_BUSY: begin
        if (meas_done_in && !sel_wr) begin
          nxt_meas_st = RMLS_MEAS_IDLE;
        end
      end
      default: nxt_meas_st = RMLS_MEAS_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meas_st_ff <= RMLS_MEAS_IDLE;
      meas_start_ff <= 1'b0;
    end else begin
      meas_st_ff <= nxt_meas_st;
      meas_start_ff <= sel_wr;
    end
  end

  // result capture, 20 mA per step
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      load_msb_ff <= 1'b0;
      load_low_ff <= 8'h00;
    end else if (meas_done_in && (meas_st_ff == RMLS_MEAS_BUSY)) begin
      load_msb_ff <= meas_value_in[8];
      load_low_ff <= meas_value_in[7:0];
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    nxt_rd_data = 8'h00;
    case (req_in.addr)
      RMLS_OFS_TOP_MASK_FIRST: nxt_rd_data = top_mask_first_ff;
      RMLS_OFS_TOP_MASK_SECOND: nxt_rd_data = top_mask_second_ff;
      RMLS_OFS_SW_MASK: nxt_rd_data = sw_mask_ff;
      RMLS_OFS_LIN_MASK: nxt_rd_data = lin_mask_ff;
      RMLS_OFS_LOAD_SEL: nxt_rd_data = load_sel_ff;
      RMLS_OFS_LOAD_HIGH: nxt_rd_data = {7'h00, load_msb_ff};
      RMLS_OFS_LOAD_LOW: nxt_rd_data = load_low_ff;
      default: nxt_rd_data = 8'h00;
    endcase
  end

  // read data holds until the next read
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_ff <= 8'h00;
    end else if (req_in.rd) begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data_out = rd_data_ff;
  assign flags_out = flags_ff;
  assign raw_seen_out = raw_seen_ff;
  assign meas_start_out = meas_start_ff;
  assign meas_sel_out = load_sel_ff[RMLS_POS_BUCK_SELECT];
  assign meas_busy_out = meas_st_ff[1];

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  AST_RESET_MASK_BLOCKS: assert property (
    (reset_reg_event_in && top_mask_second_ff[0]) |=> !$rose(flags_ff.reset_reg))
    else $error("reset-register flag set while blocked");
  // release edge still shows the reset constant; only the edge after it loads
  AST_RESET_MASK_OTP: assert property (
    (otp_load_ff && !rst_in) |=> top_mask_second_ff[0] == $past(otp_reset_reg_block_in))
    else $error("reset-register mask not reloaded after reset");
  AST_SW_FALL_GATED: assert property (
    (fall_evt[0] && !sw_mask_ff[3]) |=> flags_ff.pg[0])
    else $error("buck0 invalid event lost");
  AST_SW_RISE_GATED: assert property (
    (rise_evt[1] && sw_mask_ff[6] && !(fall_evt[1] && !sw_mask_ff[7])
     && !flags_ff.pg[1]) |=> !flags_ff.pg[1])
    else $error("buck1 valid event not blocked");
  AST_SW_OC_GATED: assert property (
    $rose(flags_ff.oc[1]) |-> $past(oc_evt[1] && !sw_mask_ff[4]))
    else $error("buck1 current-limit flag without cause");
  AST_RAW_FOLLOWS: assert property (
    ##1 raw_seen_out.pg[1:0] == $past(raw_in.pg[1:0]))
    else $error("buck raw status disturbed");
  AST_LIN_PG_GATED: assert property (
    $rose(flags_ff.pg[3]) |-> $past((fall_evt[3] && !lin_mask_ff[7])
      || (rise_evt[3] && !lin_mask_ff[6])))
    else $error("linear1 power-good flag without cause");
  AST_LIN_RISE_GATED: assert property (
    (rise_evt[2] && !lin_mask_ff[2]) |=> flags_ff.pg[2])
    else $error("linear0 valid event lost");
  AST_LIN_OC_GATED: assert property (
    (oc_evt[2] && lin_mask_ff[0] && !flags_ff.oc[2]) |=> !flags_ff.oc[2])
    else $error("linear0 current-limit not blocked");
  AST_LIN_RAW_FOLLOWS: assert property (
    ##1 raw_seen_out.oc[3:2] == $past(raw_in.oc[3:2]))
    else $error("linear raw status disturbed");
  AST_SEL_TRACKS: assert property (
    sel_wr |=> meas_sel_out == $past(req_in.wdata[0]))
    else $error("select bit not taken");
  AST_START_ON_WRITE: assert property (
    meas_start_out |-> $past(sel_wr) ##0 meas_busy_out)
    else $error("start without select write");
  AST_RESULT_CAPTURE: assert property (
    (meas_done_in && meas_busy_out) |=> {load_msb_ff, load_low_ff} == $past(meas_value_in))
    else $error("result not captured");
  AST_READY_FLAG: assert property (
    (meas_done_in && meas_busy_out && !top_mask_first_ff[0]) |=> flags_ff.meas_ready)
    else $error("measurement ready lost");
  AST_INDEPENDENT_DIR: assert property (
    (fall_evt[0] && !sw_mask_ff[3] && sw_mask_ff[2]) |=> flags_ff.pg[0])
    else $error("rise mask affects fall");
  AST_RESERVED_ZERO: assert property (
    (sw_mask_ff[5] == 1'b0) && (sw_mask_ff[1] == 1'b0) && (lin_mask_ff[5] == 1'b0))
    else $error("reserved mask bit set");
  AST_LIN_RESERVED_ZERO: assert property (
    lin_mask_ff[1] == 1'b0)
    else $error("linear reserved mask bit set");

  COV_MEAS_DONE: cover property (sel_wr ##[1:20] (meas_done_in && meas_busy_out));
  COV_PG_FLAG: cover property ($rose(flags_ff.pg[0]));
  COV_SET_CLEAR: cover property (pg_set[2] && flag_clr_in.pg[2]);
  COV_RESTART: cover property (meas_busy_out && sel_wr);

endmodule : rmls_top
`default_nettype wire

// >>> tb/rmls_host_model.sv
// Purpose: host side of the register port, issuing single writes and reads
// Assumes: one request per call, strobes raised and dropped just after a rising edge
// Notes: addr and wdata stay put when idle; only the strobes mark a request
`default_nettype none
module rmls_host_model
  import rmls_pkg::*;
(
  // clock
  input wire logic clk_in,
  // register port
  input wire logic [7:0] rd_data_in,
  output var rmls_req_t req_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req_out = '0;

  // each write also retriggers a measurement when aimed at the select reg
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    req_out.wr <= 1'b0;
  endtask

  // read data is registered on the strobe edge and holds, so sample one edge later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_in);
    req_out.rd <= 1'b0;
    @(posedge clk_in);
    d = rd_data_in;
  endtask
endmodule // rmls_host_model
`default_nettype wire

// >>> tb/rmls_top_tb.sv
// Purpose: self-checking bench of the regulator mask and load select block
// Assumes: host model drives the register port, bench drives conditions and engine
// Notes: otp input at 1, dropped to 0 for one reset to see the reload itself
`default_nettype none
module rmls_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rmls_pkg::*;

  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  rmls_req_t req;
  logic [7:0] rd_data;
  rmls_raw_t raw = '0;
  logic rr_ev = 1'b0;
  logic otp = 1'b1;
  rmls_flags_t clr = '0;
  logic done = 1'b0;
  logic [8:0] value = '0;
  logic start, sel, busy;
  rmls_flags_t flags;
  rmls_raw_t seen;
  int errors = 0;
  int n_tests = 0;
  int ch, blk;
  logic [7:0] m;
  logic [7:0] ra [7] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26};
  logic [7:0] rv [7] = '{8'h91, 8'h01, 8'hDD, 8'hDD, 8'h00, 8'h00, 8'h00};
  int pos [3] = '{RMLS_POS_FALL, RMLS_POS_RISE, RMLS_POS_OC};

  always #5 clk_in = ~clk_in;

  rmls_host_model u_host (.clk_in(clk_in), .rd_data_in(rd_data), .req_out(req));

  rmls_top u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .req_in(req), .rd_data_out(rd_data),
    .raw_in(raw), .reset_reg_event_in(rr_ev), .otp_reset_reg_block_in(otp),
    .flag_clr_in(clr), .meas_done_in(done), .meas_value_in(value),
    .meas_start_out(start), .meas_sel_out(sel), .meas_busy_out(busy),
    .flags_out(flags), .raw_seen_out(seen)
  );

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp=%h got=%h", n, e, g);
    end
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    chk(n, e, d);
  endtask

  task automatic clear_flags();
    clr <= '1;
    step(1);
    clr <= '0;
    step(1);
  endtask

  task automatic pulse_rr();
    rr_ev <= 1'b1;
    step(1);
    rr_ev <= 1'b0;
    step(2);
  endtask

  task automatic pulse_rst();
    rst_in <= 1'b1;
    step(2);
    rst_in <= 1'b0;
    step(2);
  endtask

  task automatic finish_meas(input logic [8:0] v);
    step(2);
    done <= 1'b1;
    value <= v;
    step(1);
    done <= 1'b0;
    step(2);
  endtask

  task automatic report_and_stop();
    $display("TB: errors=%0d tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, well beyond the few hundred cycles the sequence needs
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end

  initial begin
    step(10);
    rst_in <= 1'b0;
    step(2);
    for (int i = 0; i < 7; i++) rchk("reset_val", ra[i], rv[i]);
    rchk("unmapped", 8'h30, 8'h00);
    u_host.wr(RMLS_OFS_SW_MASK, 8'hFF);
    rchk("sw_reserved", RMLS_OFS_SW_MASK, 8'hDD);
    u_host.wr(RMLS_OFS_LIN_MASK, 8'hFF);
    rchk("lin_reserved", RMLS_OFS_LIN_MASK, 8'hDD);
    // per channel: block one direction or the limit event at a time, then none
    for (ch = 0; ch < 4; ch++) begin
      for (blk = 0; blk < 4; blk++) begin
        m = (blk == 3) ? 8'h00 : 8'(1 << (4 * (ch % 2) + pos[blk]));
        u_host.wr((ch < 2) ? RMLS_OFS_SW_MASK : RMLS_OFS_LIN_MASK, m);
        raw.pg[ch] <= 1'b1;
        step(3);
        chk("fall_flag", {7'h00, blk != 0}, {7'h00, flags.pg[ch]});
        chk("pg_raw", 8'h01, {7'h00, seen.pg[ch]});
        clear_flags();
        raw.pg[ch] <= 1'b0;
        step(3);
        chk("rise_flag", {7'h00, blk != 1}, {7'h00, flags.pg[ch]});
        clear_flags();
        raw.oc[ch] <= 1'b1;
        step(3);
        chk("oc_flag", {7'h00, blk != 2}, {7'h00, flags.oc[ch]});
        chk("oc_raw", 8'h01, {7'h00, seen.oc[ch]});
        raw.oc[ch] <= 1'b0;
        clear_flags();
      end
    end
    pulse_rr();
    chk("rr_blocked", 8'h00, {7'h00, flags.reset_reg});
    u_host.wr(RMLS_OFS_TOP_MASK_SECOND, 8'hFE);
    rchk("top2_write", RMLS_OFS_TOP_MASK_SECOND, 8'hFE);
    pulse_rr();
    chk("rr_open", 8'h01, {7'h00, flags.reset_reg});
    // second reset must bring the mask bit back from the otp value
    pulse_rst();
    rchk("top2_reload", RMLS_OFS_TOP_MASK_SECOND, 8'h01);
    // otp at 0 tells the reload apart from the reset constant
    otp <= 1'b0;
    pulse_rst();
    rchk("top2_otp0", RMLS_OFS_TOP_MASK_SECOND, 8'h00);
    otp <= 1'b1;
    u_host.wr(RMLS_OFS_LOAD_SEL, 8'h01);
    #1 chk("meas_go", 8'h07, {5'h00, start, busy, sel});
    step(1);
    #1 chk("meas_hold", 8'h03, {5'h00, start, busy, sel});
    finish_meas(9'h1A5);
    chk("meas_idle", 8'h01, {5'h00, start, busy, sel});
    rchk("load_high", RMLS_OFS_LOAD_HIGH, 8'h01);
    rchk("load_low", RMLS_OFS_LOAD_LOW, 8'hA5);
    chk("ready_blocked", 8'h00, {7'h00, flags.meas_ready});
    u_host.wr(RMLS_OFS_TOP_MASK_FIRST, 8'h90);
    u_host.wr(RMLS_OFS_LOAD_SEL, 8'h00);
    #1 chk("meas_go0", 8'h06, {5'h00, start, busy, sel});
    finish_meas(9'h05A);
    chk("ready_open", 8'h01, {7'h00, flags.meas_ready});
    rchk("load_high0", RMLS_OFS_LOAD_HIGH, 8'h00);
    // a stray completion while idle must not disturb the stored result
    finish_meas(9'h1FF);
    rchk("load_kept", RMLS_OFS_LOAD_LOW, 8'h5A);
    report_and_stop();
  end
endmodule // rmls_top_tb
`default_nettype wire
